// File: design/ltx_laser_ctrl.sv
// Transmitter disable and fault control of an optical transceiver.
// Assumes pin inputs are asynchronous; the management port is on clk.
//
// Behaviour
// - A high laser_off_request turns the laser off, a low one allows it.
// - Soft disable bit 6 of byte 110 is ORed with the hardware request.
// - Bit 7 of byte 110 reads back the request input level.
// - After a fault a toggle of the request resets the transmitter.
// - A laser fault or low supply raises the fault flag and stops the laser.
// - The fault flag is low in normal operation and high on a fault.
// - A laser fault latches the flag until a request toggle or power cycle.
// - A low supply fault alone does not latch and clears by itself.
// - Bit 2 of byte 110 mirrors the transmitter fault condition.
// - An eye-safety power trip counts as a laser fault.
// - rx_signal_lost follows the loss of signal and shows in bit 1.
`include "ltx_regs.svh"

module ltx_laser_ctrl
  import ltx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  input  wire logic       laserOffRequest,
  input  wire logic       laserFaultDetect,
  input  wire logic       eyeSafetyTrip,
  input  wire logic       supplyLow,
  input  wire logic       rxLossDetect,
  input  wire logic       mgmtWrEn,
  input  wire logic [7:0] mgmtAddr,
  input  wire logic [7:0] mgmtWrData,
  input  wire logic       faultPinIn,
  output logic      [7:0] mgmtRdData,
  output logic            laserEnable,
  output logic            laserFaultFlag,
  output logic            faultPinOut,
  output logic            faultPinOeN,
  output logic            rxSignalLost
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [4:0] rawIn;
  logic [4:0] syncIn;
  logic       reqSync;
  logic       faultSync;
  logic       eyeSync;
  logic       lowSync;
  logic       losSync;

  assign rawIn = {laserOffRequest, laserFaultDetect, eyeSafetyTrip,
                  supplyLow, rxLossDetect};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : gSync
      ltx_sync uSync (
        .clk     (clk),
        .rstn    (rstn),
        .clkEn   (clkEn),
        .asyncIn (rawIn[gi]),
        .syncOut (syncIn[gi])
      );
    end
  endgenerate

  assign {reqSync, faultSync, eyeSync, lowSync, losSync} = syncIn;

  ////////////////////////////////////////////////////////////////////////////
  // Management byte: soft disable is the only writable bit

  logic softOff;
  logic next_softOff;
  logic ctrlSel;
  logic offCmd;
  logic laserFaultNow;

  assign ctrlSel       = (mgmtAddr == `LTX_CTRL_STATUS_ADDR);
  assign offCmd        = reqSync | softOff;
  assign laserFaultNow = faultSync | eyeSync;

  always_comb begin
    next_softOff = softOff;
    if (clkEn && mgmtWrEn && ctrlSel) begin
      next_softOff = mgmtWrData[`LTX_BIT_SOFT_OFF];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      softOff <= `LTX_SOFT_OFF_RESET;
    end else begin
      softOff <= next_softOff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch: held until the request is asserted and then released

  ltx_state_t state;
  ltx_state_t next_state;

  always_comb begin
    next_state = state;
    if (clkEn) begin
      case (state)
        LTX_RUN: begin
          if (laserFaultNow) begin
            next_state = LTX_FAULT_HELD;
          end
        end
        LTX_FAULT_HELD: begin
          if (reqSync) begin
            next_state = LTX_FAULT_ARMED;
          end
        end
        LTX_FAULT_ARMED: begin
          // A fault still present at release keeps the latch set
          if (!reqSync && !laserFaultNow) begin
            next_state = LTX_RUN;
          end else if (!reqSync) begin
            next_state = LTX_FAULT_HELD;
          end
        end
        default: begin
          next_state = LTX_FAULT_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= LTX_RUN;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered

  logic       faultCond;
  logic       next_laserEnable;
  logic       next_laserFaultFlag;
  logic       next_rxSignalLost;
  logic [7:0] next_mgmtRdData;

  // Low supply adds to the flag without touching the latch
  assign faultCond = (next_state != LTX_RUN) | lowSync;

  always_comb begin
    next_laserEnable    = laserEnable;
    next_laserFaultFlag = laserFaultFlag;
    next_rxSignalLost   = rxSignalLost;
    next_mgmtRdData     = mgmtRdData;
    if (clkEn) begin
      next_laserEnable    = !offCmd && !faultCond;
      next_laserFaultFlag = faultCond;
      next_rxSignalLost   = losSync;
      next_mgmtRdData     = 8'h00;
      if (ctrlSel) begin
        next_mgmtRdData[`LTX_BIT_REQ_STATE] = reqSync;
        next_mgmtRdData[`LTX_BIT_SOFT_OFF]  = next_softOff;
        next_mgmtRdData[`LTX_BIT_TX_FAULT]  = faultCond;
        next_mgmtRdData[`LTX_BIT_RX_LOST]   = losSync;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      laserEnable    <= 1'b0;
      laserFaultFlag <= 1'b0;
      faultPinOut    <= 1'b0;
      faultPinOeN    <= 1'b0;
      rxSignalLost   <= 1'b0;
      mgmtRdData     <= 8'h00;
    end else begin
      laserEnable    <= next_laserEnable;
      laserFaultFlag <= next_laserFaultFlag;
      faultPinOut    <= 1'b0;
      // Open collector: drive low when healthy, release for the pull-up
      faultPinOeN    <= next_laserFaultFlag;
      rxSignalLost   <= next_rxSignalLost;
      mgmtRdData     <= next_mgmtRdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_off_request_stops: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && reqSync |=> !laserEnable)
    else $error("laser enabled while request high");

  a_soft_off_stops: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && softOff |=> !laserEnable)
    else $error("laser enabled while soft disable set");

  a_req_readback: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && ctrlSel |=> mgmtRdData[7] == $past(reqSync))
    else $error("request readback wrong");

  a_fault_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && (laserFaultNow || lowSync) |=> laserFaultFlag && !laserEnable)
    else $error("fault did not raise flag");

  a_flag_pin_level: assert property (@(posedge clk) disable iff (!rstn)
    faultPinOeN == laserFaultFlag && !faultPinOut)
    else $error("fault pin disagrees with flag");

  // A request already high at the trip may arm and release the latch
  a_fault_latches: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && laserFaultNow && !reqSync ##1 (clkEn && !reqSync)[*3]
      |=> laserFaultFlag)
    else $error("laser fault flag did not hold");

  a_toggle_clears: assert property (@(posedge clk) disable iff (!rstn)
    state == LTX_FAULT_ARMED && clkEn && !reqSync && !laserFaultNow
      && !lowSync |=> !laserFaultFlag)
    else $error("toggle did not clear fault");

  a_low_supply_free: assert property (@(posedge clk) disable iff (!rstn)
    state == LTX_RUN && clkEn && lowSync && !laserFaultNow
      ##1 clkEn && !lowSync && !laserFaultNow |=> !laserFaultFlag)
    else $error("low supply fault latched");

  a_status_fault: assert property (@(posedge clk) disable iff (!rstn)
    $past(clkEn && ctrlSel) |-> mgmtRdData[2] == laserFaultFlag)
    else $error("status fault bit wrong");

  a_eye_trip_fault: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && eyeSync |=> state != LTX_RUN)
    else $error("eye trip ignored");

  a_rx_lost: assert property (@(posedge clk) disable iff (!rstn)
    clkEn |=> rxSignalLost == $past(losSync))
    else $error("rx lost output wrong");

  a_no_restart_held: assert property (@(posedge clk) disable iff (!rstn)
    state != LTX_RUN |-> !laserEnable)
    else $error("laser restarted before toggle");

endmodule

// File: design/ltx_regs.svh
// Offsets, bit positions and reset values of the transmitter control block.
// Included by the package and by the control module; definitions only.
`ifndef LTX_REGS_SVH
`define LTX_REGS_SVH

`define LTX_CTRL_STATUS_ADDR  8'h6e
`define LTX_BIT_REQ_STATE     7
`define LTX_BIT_SOFT_OFF      6
`define LTX_BIT_TX_FAULT      2
`define LTX_BIT_RX_LOST       1
`define LTX_SOFT_OFF_RESET    1'b0
`define LTX_SYNC_STAGES       2

`endif

// File: design/ltx_pkg.sv
// Types shared by the transmitter control block.
// Assumes ltx_regs.svh is on the include path.
`include "ltx_regs.svh"

package ltx_pkg;

  typedef enum logic [1:0] {
    LTX_RUN,
    LTX_FAULT_HELD,
    LTX_FAULT_ARMED
  } ltx_state_t;

endpackage

// File: design/ltx_sync.sv
// Two flip-flop synchroniser for one asynchronous level.
// Assumes clk is free running; the clock enable freezes both stages.
module ltx_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic clkEn,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1;
  logic next_stage1;
  logic next_syncOut;

  // First stage is read by the second stage only
  always_comb begin
    next_stage1  = clkEn ? asyncIn : stage1;
    next_syncOut = clkEn ? stage1 : syncOut;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule

// File: sim/ltx_host_board.sv
// Host board side of the fault pin: pull-up on the open-drain line.
// Assumes the design drives low while its enable is low.
module ltx_host_board (
  input  wire logic faultPinOut,
  input  wire logic faultPinOeN,
  output logic      faultPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released line floats to the pull-up level
  assign faultPin = faultPinOeN ? 1'b1 : faultPinOut;
endmodule

// File: sim/laser_tx_disable_fault_control_test.sv
// Self-checking bench for the transmitter control block.
// Assumes 125 MHz clk and three enabled edges from pin to output.
module laser_tx_disable_fault_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [4:0]  pins;
    logic [11:0] exp;
  } ltx_row_t;
  logic       clk = 1'b0, rstn = 1'b0, clkEn = 1'b1, mgmtWrEn = 1'b0;
  logic       req = 1'b0, lFault = 1'b0, eye = 1'b0, sup = 1'b0, rx = 1'b0;
  logic [7:0] mgmtAddr = 8'h6e, mgmtWrData = 8'h00, mgmtRdData;
  logic       laserEnable, laserFaultFlag, faultPinOut, faultPinOeN;
  logic       rxSignalLost, faultPin;
  int         failures = 0, compares = 0;
  // {request, laser fault, eye trip, supply low, rx loss} ->
  // {enable, flag, pin level, rx lost, read byte}
  ltx_row_t   rows [5] = '{'{5'h00, 12'h800}, '{5'h10, 12'h080},
                           '{5'h01, 12'h902}, '{5'h02, 12'h604},
                           '{5'h00, 12'h800}};

  ltx_laser_ctrl uut (.clk(clk), .rstn(rstn), .clkEn(clkEn),
    .laserOffRequest(req), .laserFaultDetect(lFault), .eyeSafetyTrip(eye),
    .supplyLow(sup), .rxLossDetect(rx), .mgmtWrEn(mgmtWrEn),
    .mgmtAddr(mgmtAddr), .mgmtWrData(mgmtWrData), .faultPinIn(faultPin),
    .mgmtRdData(mgmtRdData), .laserEnable(laserEnable),
    .laserFaultFlag(laserFaultFlag), .faultPinOut(faultPinOut),
    .faultPinOeN(faultPinOeN), .rxSignalLost(rxSignalLost));
  ltx_host_board board (.faultPinOut(faultPinOut),
    .faultPinOeN(faultPinOeN), .faultPin(faultPin));

  initial begin
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] exp);
    logic [11:0] got;
    got = {laserEnable, laserFaultFlag, faultPin, rxSignalLost, mgmtRdData};
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Pins pass two sync stages and a register; six edges leave margin
  task automatic apply(input logic [4:0] p, input logic [11:0] exp);
    @(posedge clk);
    {req, lFault, eye, sup, rx} <= p;
    repeat (6) @(posedge clk);
    #1 check(exp);
    $display("step done at %0t", $time);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    mgmtAddr   <= a;
    mgmtWrData <= d;
    mgmtWrEn   <= 1'b1;
    @(posedge clk);
    mgmtWrEn   <= 1'b0;
    mgmtAddr   <= 8'h6e;
  endtask

  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    #1 check(12'h000);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) apply(rows[i].pins, rows[i].exp);
    // Laser fault, then eye trip: latch, arm on request, clear on release
    for (int s = 0; s < 2; s++) begin
      apply(s == 0 ? 5'h08 : 5'h04, 12'h604);
      apply(5'h00, 12'h604);
      apply(5'h10, 12'h684);
      apply(5'h00, 12'h800);
    end
    // Release while the fault persists keeps the latch set
    apply(5'h08, 12'h604);
    apply(5'h18, 12'h684);
    apply(5'h08, 12'h604);
    apply(5'h10, 12'h684);
    apply(5'h00, 12'h800);
    wr(8'h6e, 8'hff);
    apply(5'h00, 12'h040);
    wr(8'h6f, 8'h00);
    apply(5'h00, 12'h040);
    mgmtAddr <= 8'h6f;
    apply(5'h00, 12'h000);
    mgmtAddr <= 8'h6e;
    wr(8'h6e, 8'h00);
    apply(5'h00, 12'h800);
    // Power cycle clears a latched fault
    apply(5'h08, 12'h604);
    lFault <= 1'b0;
    rstn   <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(12'h000);
    rstn <= 1'b1;
    apply(5'h00, 12'h800);
    // Clock enable low freezes synchronisers and the soft bit alike
    @(posedge clk);
    clkEn <= 1'b0;
    req   <= 1'b1;
    wr(8'h6e, 8'h40);
    repeat (4) @(posedge clk);
    #1 check(12'h800);
    @(posedge clk);
    clkEn <= 1'b1;
    repeat (6) @(posedge clk);
    #1 check(12'h080);
    apply(5'h00, 12'h800);
    report_and_stop();
  end
endmodule
